// ---- verilog/tap_map.svh ----
// boundary-scan tap constants: instruction codes, chain layout, reset values
`ifndef TAP_MAP_SVH
`define TAP_MAP_SVH
`define TAP_IR_W          3
`define TAP_IR_EXTEST     3'h0
`define TAP_IR_IDENT      3'h1
`define TAP_IR_SAMPLE_Z   3'h2
`define TAP_IR_SAMPLE     3'h4
`define TAP_IR_BYPASS     3'h7
`define TAP_IR_CAPTURE    3'h1
`define TAP_BSR_LEN       108
`define TAP_CTRL_CELL     48
`define TAP_ID_W          32
`define TAP_ID_DEFAULT    32'h0000_0001
`define TAP_DATA_W        36
`endif

// ---- verilog/tap_pkg.sv ----
// boundary-scan tap types: controller states and pin groups
package tap_pkg;
  typedef enum logic [15:0] {
    ST_RESET      = 16'h0001,
    ST_IDLE       = 16'h0002,
    ST_SEL_DR     = 16'h0004,
    ST_CAP_DR     = 16'h0008,
    ST_SHIFT_DR   = 16'h0010,
    ST_EXIT1_DR   = 16'h0020,
    ST_PAUSE_DR   = 16'h0040,
    ST_EXIT2_DR   = 16'h0080,
    ST_UPD_DR     = 16'h0100,
    ST_SEL_IR     = 16'h0200,
    ST_CAP_IR     = 16'h0400,
    ST_SHIFT_IR   = 16'h0800,
    ST_EXIT1_IR   = 16'h1000,
    ST_PAUSE_IR   = 16'h2000,
    ST_EXIT2_IR   = 16'h4000,
    ST_UPD_IR     = 16'h8000
  } tap_state_t;

  // link pins from the tester, raw at the controller input and synchronised at its output
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } jtag_in_t;

  // strobes from the controller: both tck edges, the test-reset level, and the states left on the tck rising edge
  typedef struct packed {
    logic tck_rise;
    logic tck_fall;
    logic test_reset;
    logic cap_dr;
    logic shift_dr;
    logic upd_dr;
    logic cap_ir;
    logic shift_ir;
    logic upd_ir;
  } tap_ctl_t;
endpackage

// ---- verilog/tap_fsm.sv ----
// tap controller: pin synchronisers, tck edge finder and sixteen-state machine
`timescale 1ns/1ps
`include "tap_map.svh"
module tap_fsm (
  input  wire logic             clk_sys_i,
  input  wire logic             reset_n_i,
  input  wire tap_pkg::jtag_in_t pins_i,
  output tap_pkg::jtag_in_t     pins_o,
  output tap_pkg::tap_ctl_t     ctl_o,
  output tap_pkg::tap_state_t   state_o
);
  import tap_pkg::*;

  logic [2:0]  sync1_r;
  logic [2:0]  sync2_r;
  logic [2:0]  sync3_r;
  logic [2:0]  stable_r;
  tap_state_t  state_r;
  tap_state_t  state_nxt;

  // three stages; a pin counts as changed once stages two and three agree
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      sync1_r  <= 3'h0;
      sync2_r  <= 3'h0;
      sync3_r  <= 3'h0;
      stable_r <= 3'h0;
    end else begin
      sync1_r  <= {pins_i.tck, pins_i.tms, pins_i.tdi};
      sync2_r  <= sync1_r;
      sync3_r  <= sync2_r;
      for (int i = 0; i < 3; i++) begin
        if (sync2_r[i] == sync3_r[i]) stable_r[i] <= sync3_r[i];
      end
    end
  end

  wire tck_now  = (sync2_r[2] == sync3_r[2]) ? sync3_r[2] : stable_r[2];
  wire rise     = tck_now & ~stable_r[2];
  wire fall     = ~tck_now & stable_r[2];
  wire tms      = stable_r[1];

  // standard transition table, advanced on each tck rising edge
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_RESET:    state_nxt = tms ? ST_RESET    : ST_IDLE;
      ST_IDLE:     state_nxt = tms ? ST_SEL_DR   : ST_IDLE;
      ST_SEL_DR:   state_nxt = tms ? ST_SEL_IR   : ST_CAP_DR;
      ST_CAP_DR:   state_nxt = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: state_nxt = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: state_nxt = tms ? ST_UPD_DR   : ST_PAUSE_DR;
      ST_PAUSE_DR: state_nxt = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: state_nxt = tms ? ST_UPD_DR   : ST_SHIFT_DR;
      ST_UPD_DR:   state_nxt = tms ? ST_SEL_DR   : ST_IDLE;
      ST_SEL_IR:   state_nxt = tms ? ST_RESET    : ST_CAP_IR;
      ST_CAP_IR:   state_nxt = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: state_nxt = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: state_nxt = tms ? ST_UPD_IR   : ST_PAUSE_IR;
      ST_PAUSE_IR: state_nxt = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: state_nxt = tms ? ST_UPD_IR   : ST_SHIFT_IR;
      ST_UPD_IR:   state_nxt = tms ? ST_SEL_DR   : ST_IDLE;
      default:     state_nxt = ST_RESET;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) state_r <= ST_RESET;
    else if (rise)  state_r <= state_nxt;
  end

  // strobes name the state being left at this tck edge
  assign ctl_o.tck_rise   = rise;
  assign ctl_o.tck_fall   = fall;
  assign ctl_o.test_reset = (state_r == ST_RESET);
  assign ctl_o.cap_dr     = rise & (state_r == ST_CAP_DR);
  assign ctl_o.shift_dr   = rise & (state_r == ST_SHIFT_DR);
  assign ctl_o.upd_dr     = rise & (state_r == ST_UPD_DR);
  assign ctl_o.cap_ir     = rise & (state_r == ST_CAP_IR);
  assign ctl_o.shift_ir   = rise & (state_r == ST_SHIFT_IR);
  assign ctl_o.upd_ir     = rise & (state_r == ST_UPD_IR);
  assign pins_o.tck       = tck_now;
  assign pins_o.tms       = tms;
  assign pins_o.tdi       = stable_r[0];
  assign state_o          = state_r;
endmodule

// ---- verilog/sram_tap.sv ----
// boundary-scan test access port of a burst sram: instruction decode and pin control
`timescale 1ns/1ps
`include "tap_map.svh"
module sram_tap #(
  parameter int                 DATA_W  = `TAP_DATA_W,
  parameter int                 IN_W    = 56,
  parameter logic [`TAP_ID_W-1:0] ID_CODE = `TAP_ID_DEFAULT  // arbitrary value
) (
  input  wire logic              clk_sys_i,
  input  wire logic              reset_n_i,
  input  wire logic              tck_i,
  input  wire logic              tms_i,
  input  wire logic              tdi_i,
  output logic                   tdo_o,
  output logic                   tdo_oe_n_o,
  input  wire logic [IN_W-1:0]   sram_in_pad_i,
  input  wire logic              sram_reading_i,
  input  wire logic              echo_clock_int_i,
  input  wire logic              echo_clock_inv_int_i,
  input  wire logic [DATA_W-1:0] read_data_int_i,
  input  wire logic              read_data_oe_int_i,
  input  wire logic              echo_clock_pad_i,
  input  wire logic              echo_clock_inv_pad_i,
  input  wire logic [DATA_W-1:0] read_data_pad_i,
  output logic                   echo_clock_out_o,
  output logic                   echo_clock_out_inverted_o,
  output logic                   echo_clock_oe_n_o,
  output logic [DATA_W-1:0]      read_data_o,
  output logic                   read_data_oe_n_o,
  output logic [`TAP_IR_W-1:0]   instr_o
);
  import tap_pkg::*;

  localparam int CHAIN = 2 + DATA_W + 1 + IN_W;  // echo pair, data, control, inputs
  localparam int CTRL  = `TAP_CTRL_CELL;

  // chain order: [1:0] echo pair, read data, then inputs with the control cell at CTRL
  localparam int D_LO  = 2;
  localparam int C_POS = D_LO + DATA_W;  // first cell above the read data
  localparam int IN_LO = CTRL - C_POS;   // input cells below the control cell

  // the control cell must sit among the input cells, at its fixed place
  if (CTRL <= C_POS || CTRL >= CHAIN - 1) begin : g_bad_chain
    $error("boundary chain cannot hold the control cell at its fixed place");
  end
  if (DATA_W < 1 || IN_W < 1) begin : g_bad_width
    $error("widths must be positive");
  end

  jtag_in_t   pins_in;
  jtag_in_t   pins;
  tap_ctl_t   ctl;
  tap_state_t state;

  assign pins_in.tck = tck_i;
  assign pins_in.tms = tms_i;
  assign pins_in.tdi = tdi_i;

  tap_fsm u_fsm (
    .clk_sys_i (clk_sys_i),
    .reset_n_i (reset_n_i),
    .pins_i    (pins_in),
    .pins_o    (pins),
    .ctl_o     (ctl),
    .state_o   (state)
  );

  logic [`TAP_IR_W-1:0] ir_shift_r;
  logic [`TAP_IR_W-1:0] ir_r;
  logic                 bypass_r;
  logic [`TAP_ID_W-1:0] id_r;
  logic [CHAIN-1:0]     bsr_r;
  logic [CHAIN-1:0]     upd_r;
  logic                 ctrl_r;
  logic                 ext_drive_r;

  // decoding of the active instruction; reserved codes fall to bypass
  function automatic logic [4:0] decode(input logic [`TAP_IR_W-1:0] code);
    logic [4:0] d;
    d = 5'h0;
    unique case (code)
      `TAP_IR_EXTEST:   d[0] = 1'b1;
      `TAP_IR_IDENT:    d[1] = 1'b1;
      `TAP_IR_SAMPLE_Z: d[2] = 1'b1;
      `TAP_IR_SAMPLE:   d[3] = 1'b1;
      default:          d[4] = 1'b1;
    endcase
    return d;
  endfunction

  wire [4:0] dec        = decode(ir_r);
  wire       is_extest  = dec[0];
  wire       is_ident   = dec[1];
  wire       is_samplez = dec[2];
  wire       is_sample  = dec[3];
  wire       is_bypass  = dec[4];
  wire       use_bsr    = is_extest | is_samplez | is_sample;

  // capture sources per instruction for the echo pair and read-data cells
  wire       pad_cap    = is_extest | is_samplez;
  wire       echo_c0    = pad_cap ? echo_clock_pad_i     : echo_clock_int_i;
  wire       echo_c1    = pad_cap ? echo_clock_inv_pad_i : echo_clock_inv_int_i;
  wire       data_int   = is_sample & sram_reading_i;
  wire [DATA_W-1:0] data_cap = data_int ? read_data_int_i : read_data_pad_i;
  wire [CHAIN-1:0]  cap_vec  = {sram_in_pad_i[IN_W-1:IN_LO], ctrl_r, sram_in_pad_i[IN_LO-1:0],
                                data_cap, echo_c1, echo_c0};

  // instruction register; id is reloaded whenever test-logic-reset is held
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      ir_shift_r <= `TAP_IR_IDENT;
      ir_r       <= `TAP_IR_IDENT;
    end else if (ctl.test_reset) begin
      ir_r       <= `TAP_IR_IDENT;
    end else if (ctl.cap_ir) begin
      ir_shift_r <= `TAP_IR_CAPTURE;
    end else if (ctl.shift_ir) begin
      ir_shift_r <= {pins.tdi, ir_shift_r[`TAP_IR_W-1:1]};  // lsb nearest tdo
    end else if (ctl.upd_ir) begin
      ir_r       <= ir_shift_r;
    end
  end

  // bypass and identification data registers
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      bypass_r <= 1'b0;
      id_r     <= ID_CODE;
    end else if (ctl.cap_dr) begin
      bypass_r <= 1'b0;
      id_r     <= ID_CODE;
    end else if (ctl.shift_dr) begin
      bypass_r <= pins.tdi;
      id_r     <= {pins.tdi, id_r[`TAP_ID_W-1:1]};
    end
  end

  // boundary chain: capture, shift, then update cells on update-dr
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      bsr_r <= '0;
      upd_r <= '0;
    end else if (ctl.cap_dr && use_bsr) begin
      bsr_r <= cap_vec;
    end else if (ctl.shift_dr && use_bsr) begin
      bsr_r <= {pins.tdi, bsr_r[CHAIN-1:1]};
    end else if (ctl.upd_dr && use_bsr) begin
      upd_r <= bsr_r;
    end
  end

  // control cell and extest drive; update-ir of extest enables preloaded data
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      ctrl_r      <= 1'b0;
      ext_drive_r <= 1'b0;
    end else begin
      if (ctl.upd_dr && (is_extest || is_sample)) ctrl_r <= bsr_r[CTRL];
      if (ctl.test_reset)                         ext_drive_r <= 1'b0;
      else if (ctl.upd_ir)                        ext_drive_r <= (ir_shift_r == `TAP_IR_EXTEST);
    end
  end

  // tdo changes on the tck falling edge from the selected register's lsb
  wire tdo_sel = is_bypass ? bypass_r :
                 is_ident  ? id_r[0]  : bsr_r[0];
  wire in_shift = (state == ST_SHIFT_DR) | (state == ST_SHIFT_IR);
  wire tdo_bit  = (state == ST_SHIFT_IR) ? ir_shift_r[0] : tdo_sel;

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      tdo_o      <= 1'b0;
      tdo_oe_n_o <= 1'b1;
    end else if (ctl.tck_fall) begin
      tdo_o      <= tdo_bit;
      tdo_oe_n_o <= ~in_shift;
    end
  end

  // pin muxing: extest uses update cells, sample-z floats, others pass sram
  wire ext_on     = is_extest & ext_drive_r;
  wire echo_v     = ext_on ? upd_r[0] : echo_clock_int_i;
  wire echo_inv_v = ext_on ? upd_r[1] : echo_clock_inv_int_i;
  wire echo_oe_n  = is_samplez;
  wire [DATA_W-1:0] data_v = ext_on ? upd_r[C_POS-1:D_LO] : read_data_int_i;
  wire data_oe_n  = is_samplez ? 1'b1 :
                    is_extest  ? ~(ext_on & ctrl_r) :
                                 ~read_data_oe_int_i;

  // registered pin outputs; a cycle of delay is fine against the sram clocks
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      echo_clock_out_o          <= 1'b0;
      echo_clock_out_inverted_o <= 1'b0;
      echo_clock_oe_n_o         <= 1'b0;
      read_data_o               <= '0;
      read_data_oe_n_o          <= 1'b1;
      instr_o                   <= `TAP_IR_IDENT;
    end else begin
      echo_clock_out_o          <= echo_v;
      echo_clock_out_inverted_o <= echo_inv_v;
      echo_clock_oe_n_o         <= echo_oe_n;
      read_data_o               <= data_v;
      read_data_oe_n_o          <= data_oe_n;
      instr_o                   <= ir_r;
    end
  end
endmodule

// ---- sim/sram_tap_checker.sv ----
// pin-level assertion checker for the sram boundary-scan tap
`timescale 1ns/1ps
`include "tap_map.svh"
module sram_tap_checker #(
  parameter int DATA_W = `TAP_DATA_W
) (
  input wire logic              clk_sys_i,
  input wire logic              reset_n_i,
  input wire logic              tdo_oe_n_o,
  input wire logic              echo_clock_int_i,
  input wire logic              echo_clock_inv_int_i,
  input wire logic [DATA_W-1:0] read_data_int_i,
  input wire logic              read_data_oe_int_i,
  input wire logic              echo_clock_out_o,
  input wire logic              echo_clock_out_inverted_o,
  input wire logic              echo_clock_oe_n_o,
  input wire logic [DATA_W-1:0] read_data_o,
  input wire logic              read_data_oe_n_o,
  input wire logic [2:0]        instr_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  // an instruction held for two cycles, so registered pins have caught up
  sequence s_held(logic [2:0] code);
    instr_o == code && $past(instr_o) == code && $past(reset_n_i);
  endsequence
  // one of the instructions that leave the sram in charge of its pins
  sequence s_normal;
    (instr_o == `TAP_IR_IDENT || instr_o == `TAP_IR_SAMPLE || instr_o == `TAP_IR_BYPASS)
      && $past(instr_o) == instr_o && $past(reset_n_i);
  endsequence
  a_reset_defaults: assert property ($rose(reset_n_i) |-> instr_o == `TAP_IR_IDENT
    && tdo_oe_n_o && !echo_clock_oe_n_o) else $error("reset left wrong defaults");
  a_samplez_data: assert property (s_held(`TAP_IR_SAMPLE_Z) |-> read_data_oe_n_o)
    else $error("read data driven under sample-z");
  a_samplez_echo: assert property (s_held(`TAP_IR_SAMPLE_Z) |-> echo_clock_oe_n_o)
    else $error("echo clocks driven under sample-z");
  a_normal_echo: assert property (s_normal |-> !echo_clock_oe_n_o
    && echo_clock_out_o == $past(echo_clock_int_i)
    && echo_clock_out_inverted_o == $past(echo_clock_inv_int_i)) else $error("echo not sram");
  a_normal_data: assert property (s_normal |-> read_data_o == $past(read_data_int_i))
    else $error("read data not from sram");
  a_normal_oe: assert property (s_normal |-> read_data_oe_n_o == !$past(read_data_oe_int_i))
    else $error("read data enable not from sram");
  a_extest_echo: assert property (s_held(`TAP_IR_EXTEST) |-> !echo_clock_oe_n_o)
    else $error("echo clocks floating under extest");
  a_ir_not_shifting: assert property ($changed(instr_o) |-> tdo_oe_n_o)
    else $error("instruction changed while tdo driving");
endmodule

bind sram_tap sram_tap_checker #(.DATA_W(DATA_W)) u_chk (
  .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .tdo_oe_n_o(tdo_oe_n_o),
  .echo_clock_int_i(echo_clock_int_i), .echo_clock_inv_int_i(echo_clock_inv_int_i),
  .read_data_int_i(read_data_int_i), .read_data_oe_int_i(read_data_oe_int_i),
  .echo_clock_out_o(echo_clock_out_o), .echo_clock_out_inverted_o(echo_clock_out_inverted_o),
  .echo_clock_oe_n_o(echo_clock_oe_n_o), .read_data_o(read_data_o),
  .read_data_oe_n_o(read_data_oe_n_o), .instr_o(instr_o));

// ---- sim/jtag_tester.sv ----
// behavioural boundary-scan tester: drives tck, tms, tdi and reads tdo
`timescale 1ns/1ps
module jtag_tester (
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o,
  input  wire logic tdo_i
);
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end
  // one 80 ns tck period; tdo is read late in the high phase because the
  // device answers several system clocks after each tck fall
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    tms_o = tms;
    tdi_o = tdi;
    #20 tck_o = 1'b1;
    #40 tdo = tdo_i;
    tck_o = 1'b0;
    #20;
  endtask
  // five tms highs reach test-logic-reset from anywhere, then park in idle
  task automatic to_idle();
    logic d;
    for (int i = 0; i < 6; i++) begin
      step(i < 5, 1'b0, d);
    end
  endtask
  // idle, capture, n shift bits lsb first, update, back to idle; tck then stands low
  // callers shift in only four of the five defined instruction codes (not ident), never a reserved one
  task automatic scan(input logic ir, input int n, input logic [127:0] din,
                      output logic [127:0] dout);
    logic d;
    dout = '0;
    step(1'b1, 1'b0, d);
    if (ir) begin
      step(1'b1, 1'b0, d);
    end
    step(1'b0, 1'b0, d);
    step(1'b0, 1'b0, d);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], dout[i]);
    end
    step(1'b1, 1'b0, d);
    step(1'b0, 1'b0, d);
    tdi_o = ~tdi_o;  // no stale level once released
  endtask
endmodule

// ---- sim/sram_tap_tb.sv ----
// self-checking bench for the sram boundary-scan tap
`timescale 1ns/1ps
`include "tap_map.svh"
module sram_tap_tb;
  localparam logic [35:0] INT_DATA = 36'h123456789;
  localparam logic [35:0] PAD_DATA = 36'hfedcba987;
  localparam logic [35:0] UPD_DATA = 36'h5a5a0f0f3;
  localparam int          CHAIN_LEN = 2 + 36 + 1 + 56;  // echo pair, data, control, inputs
  logic         clk_sys_i, reset_n_i, tck, tms, tdi, tdo, tdo_oe_n, reading, oe_int;
  logic         ec_int, ec_inv_int, ec_pad, ec_inv_pad, eco, ecoi, echo_oe_n, rdata_oe_n;
  logic [35:0]  rd_int, rd_pad, rdata;
  logic [55:0]  in_pad;
  logic [2:0]   instr;
  logic [127:0] so;
  int           failures = 0;
  int           comparisons = 0;
  sram_tap dut (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .tdo_o(tdo), .tdo_oe_n_o(tdo_oe_n), .sram_in_pad_i(in_pad), .sram_reading_i(reading),
    .echo_clock_int_i(ec_int), .echo_clock_inv_int_i(ec_inv_int), .read_data_int_i(rd_int),
    .read_data_oe_int_i(oe_int), .echo_clock_pad_i(ec_pad), .echo_clock_inv_pad_i(ec_inv_pad),
    .read_data_pad_i(rd_pad), .echo_clock_out_o(eco), .echo_clock_out_inverted_o(ecoi),
    .echo_clock_oe_n_o(echo_oe_n), .read_data_o(rdata), .read_data_oe_n_o(rdata_oe_n),
    .instr_o(instr));
  jtag_tester jt (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo));
  task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d, failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // preload: echo 0, inverted echo 1, fixed data, chosen output-control bit
  function automatic logic [127:0] chain(input logic ctrl);
    chain = '0;
    chain[1:0] = 2'b10;
    chain[37:2] = UPD_DATA;
    chain[`TAP_CTRL_CELL] = ctrl;
  endfunction
  task automatic t_ident();
    check("reset instruction", instr, `TAP_IR_IDENT);
    jt.to_idle();
    jt.scan(1'b0, 32, '0, so);
    check("id value", so[31:0], `TAP_ID_DEFAULT);
    check("echo pins", {eco, ecoi, echo_oe_n, rdata_oe_n}, 4'b1000);
    $display("test ident done");
  endtask
  task automatic t_bypass();
    jt.scan(1'b1, 3, 128'(`TAP_IR_BYPASS), so);
    check("ir capture", so[2:0], `TAP_IR_CAPTURE);
    check("bypass instr", instr, `TAP_IR_BYPASS);
    jt.scan(1'b0, 8, 128'hb5, so);
    check("bypass path", so[7:0], 8'h6a);
    $display("test bypass done");
  endtask
  task automatic t_sample();
    jt.scan(1'b1, 3, 128'(`TAP_IR_SAMPLE), so);
    check("sample instr", instr, `TAP_IR_SAMPLE);
    jt.scan(1'b0, CHAIN_LEN, chain(1'b1), so);
    check("echo capture", so[1:0], 2'b01);
    check("data capture", so[37:2], INT_DATA);
    check("input capture", {so[94:49], so[47:38]}, in_pad);
    check("control capture", so[48], 1'b0);
    check("sample pins", rdata, INT_DATA);
    @(negedge clk_sys_i);
    reading = 1'b0;  // sram idle; inputs held still over the capture
    jt.scan(1'b0, CHAIN_LEN + 8, (chain(1'b1) << 8) | 128'hc3, so);
    check("idle capture", so[37:2], PAD_DATA);
    check("control set", so[48], 1'b1);
    check("chain length", so[102:95], 8'hc3);
    $display("test sample done");
  endtask
  task automatic t_samplez();
    jt.scan(1'b1, 3, 128'(`TAP_IR_SAMPLE_Z), so);
    check("float", {echo_oe_n, rdata_oe_n}, 2'b11);
    jt.scan(1'b0, CHAIN_LEN + 8, (chain(1'b0) << 8) | 128'h3c, so);
    check("pad capture", so[37:0], {PAD_DATA, 2'b10});
    check("boundary path", so[102:95], 8'h3c);
    $display("test sample-z done");
  endtask
  // control bit must still be 1: the sample-z update may not have cleared it
  task automatic t_extest();
    jt.scan(1'b1, 3, 128'(`TAP_IR_EXTEST), so);
    check("extest drive", {eco, ecoi, rdata_oe_n}, 3'b010);
    check("extest data", rdata, UPD_DATA);
    jt.scan(1'b0, CHAIN_LEN, chain(1'b0), so);
    check("extest capture", so[37:0], {PAD_DATA, 2'b10});
    check("extest inputs", {so[94:49], so[47:38]}, in_pad);
    check("control kept", so[48], 1'b1);
    check("control off", rdata_oe_n, 1'b1);
    $display("test extest done");
  endtask
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // watchdog: a hang counts as a failure
  initial begin
    repeat (60000) @(posedge clk_sys_i);
    failures++;
    stop_test();
  end
  initial begin
    reset_n_i = 1'b0;
    reading = 1'b1;
    oe_int = 1'b1;
    ec_int = 1'b1;
    ec_inv_int = 1'b0;
    ec_pad = 1'b0;
    ec_inv_pad = 1'b1;
    rd_int = INT_DATA;
    rd_pad = PAD_DATA;
    in_pad = 56'h0f1e2d3c4b5a69;
    repeat (3) @(negedge clk_sys_i);
    reset_n_i = 1'b1;
    repeat (5) @(negedge clk_sys_i);
    t_ident();
    t_bypass();
    t_sample();
    t_samplez();
    t_extest();
    stop_test();
  end
endmodule
